/* src/srw_top.sv */
// Purpose : reset generator, watchdog and power-fail flag for a host
// Assumes : supply flag, comparator, manual reset and kick are asynchronous
// Notes   : outputs all come from flip-flops; counts shortenable by parameter
`timescale 1ns/100ps
`default_nettype none
module srw_top #(
    parameter int unsigned HOLD_CYCLES = srw_pkg::HOLD_CYCLES,
    parameter int unsigned WD_CYCLES   = srw_pkg::WD_CYCLES
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_supply_low,
    input  wire logic i_manual_reset_n_in,
    input  wire logic i_power_fail_sense_in,
    input  wire logic i_watchdog_kick_in,
    output var  logic o_reset_n,
    output var  logic o_reset,
    output var  logic o_power_fail_flag_n,
    output var  logic o_watchdog_expired_n
);
    localparam logic [srw_pkg::CNT_W-1:0] HOLD_LAST = srw_pkg::CNT_W'(HOLD_CYCLES - 1);
    localparam logic [srw_pkg::CNT_W-1:0] WD_LAST   = srw_pkg::CNT_W'(WD_CYCLES - 1);

    srw_pkg::srw_inputs_t  raw;
    wire srw_pkg::srw_inputs_t syn;
    srw_pkg::srw_state_t   state_r;
    logic [srw_pkg::CNT_W-1:0] hold_cnt_r;
    logic [srw_pkg::CNT_W-1:0] wd_cnt_r;
    logic                  kick_d_r;
    logic                  wd_timeout_r;
    logic                  trigger;
    logic                  kick_edge;

    assign raw = '{supply_low:       i_supply_low,
                   manual_reset_n:   i_manual_reset_n_in,
                   power_fail_sense: i_power_fail_sense_in,
                   kick:             i_watchdog_kick_in};

    // ****************************************
    // input synchronisers
    // ****************************************
    // supply flag assumed set at start so power-on still holds off
    srw_sync #(.INIT(srw_pkg::LEVEL_RESET)) u_sync_supply (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (raw.supply_low),
        .o_sync    (syn.supply_low)
    );
    srw_sync #(.INIT(srw_pkg::LEVEL_RESET)) u_sync_mr (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (raw.manual_reset_n),
        .o_sync    (syn.manual_reset_n)
    );
    srw_sync #(.INIT(srw_pkg::LEVEL_RESET)) u_sync_pf (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (raw.power_fail_sense),
        .o_sync    (syn.power_fail_sense)
    );
    srw_sync #(.INIT(srw_pkg::KICK_RESET)) u_sync_kick (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (raw.kick),
        .o_sync    (syn.kick)
    );

    // ****************************************
    // reset hold-off
    // ****************************************
    // any low manual level or supply low retriggers; switch bounce
    // only restarts the hold-off, giving debounce for free
    assign trigger = syn.supply_low | ~syn.manual_reset_n;

    // state and hold counter
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_r    <= srw_pkg::SRW_HOLD;
            hold_cnt_r <= '0;
        end else begin
            case (state_r)
                srw_pkg::SRW_RUN: begin
                    hold_cnt_r <= '0;
                    if (trigger) begin
                        state_r <= srw_pkg::SRW_HOLD;
                    end
                end
                srw_pkg::SRW_HOLD: begin
                    if (trigger) begin
                        hold_cnt_r <= '0;
                    end else if (hold_cnt_r == HOLD_LAST) begin
                        state_r    <= srw_pkg::SRW_RUN;
                        hold_cnt_r <= '0;
                    end else begin
                        hold_cnt_r <= hold_cnt_r + 1'h1;
                    end
                end
                default: begin
                    state_r    <= srw_pkg::SRW_HOLD;
                    hold_cnt_r <= '0;
                end
            endcase
        end
    end

    // reset outputs, complementary
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_reset_n <= srw_pkg::RST_N_RESET;
            o_reset   <= ~srw_pkg::RST_N_RESET;
        end else begin
            o_reset_n <= (state_r == srw_pkg::SRW_RUN) & ~trigger;
            o_reset   <= ~((state_r == srw_pkg::SRW_RUN) & ~trigger);
        end
    end

    // ****************************************
    // power-fail flag
    // ****************************************
    // sense input high means above threshold
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_power_fail_flag_n <= srw_pkg::PF_N_RESET;
        end else begin
            o_power_fail_flag_n <= syn.power_fail_sense;
        end
    end

    // ****************************************
    // watchdog
    // ****************************************
    // kick edge detect on the synchronised level
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            kick_d_r <= srw_pkg::KICK_RESET;
        end else begin
            kick_d_r <= syn.kick;
        end
    end

    assign kick_edge = syn.kick ^ kick_d_r;

    // timeout counter, cleared by edges and by reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            wd_cnt_r     <= '0;
            wd_timeout_r <= 1'h0;
        end else if (kick_edge || !o_reset_n) begin
            wd_cnt_r     <= '0;
            wd_timeout_r <= 1'h0;
        end else if (wd_cnt_r == WD_LAST) begin
            wd_timeout_r <= 1'h1;
        end else begin
            wd_cnt_r <= wd_cnt_r + 1'h1;
        end
    end

    // expiry output; supply low overrides, drops at once on recovery
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_watchdog_expired_n <= srw_pkg::WD_N_RESET;
        end else begin
            o_watchdog_expired_n <= ~syn.supply_low & ~wd_timeout_r;
        end
    end
endmodule
`default_nettype wire

/* src/srw_pkg.sv */
// Purpose : constants and carrier types for the supervisor reset watchdog
// Assumes : 50 MHz system clock, synchronous active-low reset
// Notes   : all timing counts are derived from times in their own unit
//
// Functional notes
// - manual low or supply low starts reset
// - manual reset input is debounced internally
// - reset output held low 200 ms
// - reset low while supply flag set
// - release 200 ms after trigger clears
// - watchdog expiry never resets by itself
// - active-high reset is inverse of low
// - power-fail output follows comparator result
// - steady kick past timeout drives expiry low
// - every kick edge clears watchdog counter
// - counter held cleared during reset
// - expiry stays low until counter cleared
// - expiry forced low while supply low
// - expiry returns high when supply recovers
// - watchdog timeout is 1.6 seconds
// - new trigger restarts full hold-off
package srw_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned HOLD_MS        = 200;
    localparam int unsigned WD_TIMEOUT_MS  = 1600;
    localparam int unsigned HOLD_CYCLES    = HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned WD_CYCLES      = WD_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned SYNC_STAGES    = 3;
    localparam int unsigned CNT_W          = 27;

    // ****************************************
    // reset values and types
    // ****************************************
    localparam logic RST_N_RESET = 1'h0;
    localparam logic PF_N_RESET  = 1'h1;
    localparam logic WD_N_RESET  = 1'h0;
    localparam logic LEVEL_RESET = 1'h1;
    localparam logic KICK_RESET  = 1'h0;

    typedef enum logic [1:0] {
        SRW_RUN  = 2'h1,
        SRW_HOLD = 2'h2
    } srw_state_t;

    typedef struct packed {
        logic supply_low;
        logic manual_reset_n;
        logic power_fail_sense;
        logic kick;
    } srw_inputs_t;
endpackage

/* src/srw_sync.sv */
// Purpose : three-stage synchroniser for one asynchronous input
// Assumes : single clock domain
// Notes   : output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module srw_sync #(
    parameter logic INIT = 1'h1
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output var  logic o_sync
);
    logic [2:0] stage_r;

    // ****************************************
    // chain and agreement filter
    // ****************************************
    // shift chain; first stage feeds only the second
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            stage_r <= {3{INIT}};
        end else begin
            stage_r <= {stage_r[1:0], i_async};
        end
    end

    // accept a change once stages two and three agree
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_sync <= INIT;
        end else if (stage_r[1] == stage_r[2]) begin
            o_sync <= stage_r[2];
        end
    end
endmodule
`default_nettype wire

/* tb/srw_top_assertions.sv */
// Purpose : concurrent checks on the supervisor outputs
// Assumes : shortened counts handed on through the bind
// Notes   : quiet counters on the raw inputs absorb the synchroniser latency
`timescale 1ns/100ps
`default_nettype none
module srw_top_assertions #(
    parameter int unsigned HOLD_CYCLES = 50,
    parameter int unsigned WD_CYCLES   = 200
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_supply_low,
    input wire logic i_manual_reset_n_in,
    input wire logic i_power_fail_sense_in,
    input wire logic i_watchdog_kick_in,
    input wire logic o_reset_n,
    input wire logic o_reset,
    input wire logic o_power_fail_flag_n,
    input wire logic o_watchdog_expired_n
);
    // ****************************************
    // quiet counters and properties
    // ****************************************
    int unsigned tq_r;
    int unsigned kq_r;
    int unsigned sq_r;
    logic        kick_r;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // cycles since last trigger, kick edge or reset, supply low
    always_ff @(posedge i_clk_sys) begin
        kick_r <= i_watchdog_kick_in;
        tq_r   <= (!i_rst_n || i_supply_low || !i_manual_reset_n_in) ? 0 : tq_r + 1;
        kq_r   <= (!i_rst_n || !o_reset_n || kick_r != i_watchdog_kick_in) ? 0 : kq_r + 1;
        sq_r   <= (!i_rst_n || i_supply_low) ? 0 : sq_r + 1;
    end
    property p_inv; o_reset != o_reset_n; endproperty
    a_inv: assert property (p_inv) else $error("reset outputs not inverse");
    property p_sup; i_supply_low [*6] |-> !o_reset_n; endproperty
    a_sup: assert property (p_sup) else $error("reset high with supply low");
    property p_man; !i_manual_reset_n_in [*6] |-> !o_reset_n; endproperty
    a_man: assert property (p_man) else $error("reset high with manual low");
    property p_hold; $rose(o_reset_n) |-> tq_r >= HOLD_CYCLES; endproperty
    a_hold: assert property (p_hold) else $error("reset released early");
    property p_rel; tq_r >= HOLD_CYCLES + 12 |-> o_reset_n; endproperty
    a_rel: assert property (p_rel) else $error("reset not released");
    property p_nowd; !o_watchdog_expired_n && tq_r >= HOLD_CYCLES + 12 |-> o_reset_n; endproperty
    a_nowd: assert property (p_nowd) else $error("expiry caused reset");
    property p_pf; $stable(i_power_fail_sense_in) [*6] |-> o_power_fail_flag_n == i_power_fail_sense_in; endproperty
    a_pf: assert property (p_pf) else $error("power fail flag wrong");
    property p_to; kq_r >= WD_CYCLES + 8 |-> !o_watchdog_expired_n; endproperty
    a_to: assert property (p_to) else $error("no watchdog expiry");
    property p_early; !o_watchdog_expired_n && sq_r >= 10 |-> kq_r < 8 || kq_r >= WD_CYCLES; endproperty
    a_early: assert property (p_early) else $error("expiry low without timeout");
    property p_wdsup; i_supply_low [*6] |-> !o_watchdog_expired_n; endproperty
    a_wdsup: assert property (p_wdsup) else $error("expiry high with supply low");
    property p_back; $fell(i_supply_low) |-> ##[1:8] o_watchdog_expired_n; endproperty
    a_back: assert property (p_back) else $error("expiry not high after supply");
    c_rel: cover property ($rose(o_reset_n));
    c_to: cover property ($fell(o_watchdog_expired_n) && o_reset_n);
    c_pf: cover property ($fell(o_power_fail_flag_n));
endmodule
bind srw_top srw_top_assertions #(.HOLD_CYCLES(HOLD_CYCLES), .WD_CYCLES(WD_CYCLES)) srw_top_assertions_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_supply_low(i_supply_low), .i_manual_reset_n_in(i_manual_reset_n_in),
    .i_power_fail_sense_in(i_power_fail_sense_in), .i_watchdog_kick_in(i_watchdog_kick_in), .o_reset_n(o_reset_n),
    .o_reset(o_reset), .o_power_fail_flag_n(o_power_fail_flag_n), .o_watchdog_expired_n(o_watchdog_expired_n));
`default_nettype wire

/* tb/srw_host.sv */
// Purpose : host processor model driving kick and manual reset
// Assumes : kick period in cycles set by the bench
// Notes   : kick holds its level while disabled
`timescale 1ns/100ps
`default_nettype none
module srw_host (
    input  wire logic       i_clk_sys,
    input  wire logic       i_kick_en,
    input  wire logic [7:0] i_period,
    input  wire logic       i_press,
    output var  logic       o_kick,
    output var  logic       o_manual_reset_n
);
    // ****************************************
    // kick generator
    // ****************************************
    logic [7:0] cnt_r;
    initial o_kick = 1'h0;
    // toggle kick once each period while enabled
    always @(posedge i_clk_sys) begin
        cnt_r <= (!i_kick_en || cnt_r >= i_period) ? 8'h00 : cnt_r + 8'h01;
        if (i_kick_en && cnt_r >= i_period) o_kick <= #2 !o_kick;
    end
    assign o_manual_reset_n = !i_press;
endmodule
`default_nettype wire

/* tb/srw_top_bench.sv */
// Purpose : self-checking bench for the supervisor reset watchdog
// Assumes : shortened hold-off and timeout counts
// Notes   : driver notes expected outputs, monitor compares them
`timescale 1ns/100ps
`default_nettype none
module srw_top_bench;
    // ****************************************
    // bench
    // ****************************************
    localparam int HOLD = 50;
    localparam int WD   = 200;
    logic i_clk_sys = 1'h0, i_rst_n = 1'h0, supply = 1'h0, sense = 1'h1, kick_en = 1'h0, press = 1'h0;
    logic [7:0] period = 8'h0A;
    wire logic kick, manual_n, rst_n, rst, pf_n, wd_n;
    int errors = 0;
    int n_compared = 0;
    logic [3:0] notes[$];
    event chk;
    always #10 i_clk_sys = !i_clk_sys;
    srw_host srw_host_inst (.i_clk_sys(i_clk_sys), .i_kick_en(kick_en), .i_period(period), .i_press(press),
        .o_kick(kick), .o_manual_reset_n(manual_n));
    srw_top #(.HOLD_CYCLES(HOLD), .WD_CYCLES(WD)) srw_top_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_supply_low(supply), .i_manual_reset_n_in(manual_n), .i_power_fail_sense_in(sense),
        .i_watchdog_kick_in(kick), .o_reset_n(rst_n), .o_reset(rst), .o_power_fail_flag_n(pf_n),
        .o_watchdog_expired_n(wd_n));
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #2;
    endtask
    task automatic note(input logic rn, input logic pn, input logic wn);
        notes.push_back({rn, !rn, pn, wn});
        ->chk;
    endtask
    task automatic conclude;
        if (errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // monitor compares outputs against the oldest note
    initial forever begin
        logic [3:0] e;
        @(chk);
        e = notes.pop_front();
        n_compared++;
        if ({rst_n, rst, pf_n, wd_n} !== e) begin
            errors++;
            $display("FAIL outputs expected %b seen %b", e, {rst_n, rst, pf_n, wd_n});
        end
    end
    // main sequence
    initial begin
        void'($urandom(55));
        period = 8'h08 + 8'($urandom % 16);
        cyc(20);
        i_rst_n = 1'h1;
        kick_en = 1'h1;
        cyc(HOLD - 10); note(1'h0, 1'h1, 1'h1);
        cyc(25); note(1'h1, 1'h1, 1'h1);
        repeat (8) begin
            sense = 1'($urandom);
            cyc(8); note(1'h1, sense, 1'h1);
        end
        sense = 1'h1;
        repeat (20) begin
            press = 1'($urandom);
            cyc(1);
        end
        press = 1'h1;
        cyc(8); note(1'h0, 1'h1, 1'h1);
        press = 1'h0;
        cyc(HOLD / 2);
        press = 1'h1;
        cyc(8);
        press = 1'h0;
        cyc(HOLD - 10); note(1'h0, 1'h1, 1'h1);
        cyc(25); note(1'h1, 1'h1, 1'h1);
        kick_en = 1'h0;
        cyc(WD + 15); note(1'h1, 1'h1, 1'h0);
        kick_en = 1'h1;
        cyc(40); note(1'h1, 1'h1, 1'h1);
        supply = 1'h1;
        cyc(20); note(1'h0, 1'h1, 1'h0);
        supply = 1'h0;
        cyc(8); note(1'h0, 1'h1, 1'h1);
        cyc(HOLD); note(1'h1, 1'h1, 1'h1);
        cyc(2);
        conclude();
    end
    // watchdog against a hang
    initial begin
        #(20 * 20000);
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
